// ==== rtl/lcdfc_top.sv ====
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lcdfc_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        sub_clock_pin,
  input  wire logic        sysclk_tick,
  output logic             drive_enable,
  output logic             blank_display,
  output logic             waveform_b_select,
  output logic             drive_supply_on,
  output logic             divider_connected,
  output logic             frame_strobe,
  output logic             alternation_q
);
  logic [7:0]  display_control_q;
  logic [7:0]  waveform_divider_q;
  logic [7:0]  clock_gate_two_q;
  logic [7:0]  mode_control_q;
  logic [7:0]  frame_status;
  logic        sub_tick;
  logic        running;
  logic        sub_mode;
  logic [3:0]  frame_clock_select;
  logic        src_tick;
  logic [7:0]  pre_q;
  logic        op_tick;
  logic [15:0] frame_cnt_q;
  logic [15:0] frame_len;
  logic        sel_changed;
  logic [3:0]  sel_q;

  lcdfc_apb_regs u_regs (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .frame_status      (frame_status),
    .pready            (pready),
    .pslverr           (pslverr),
    .prdata            (prdata),
    .display_control_q (display_control_q),
    .waveform_divider_q(waveform_divider_q),
    .clock_gate_two_q  (clock_gate_two_q),
    .mode_control_q    (mode_control_q)
  );

  lcdfc_sub_tick u_sub (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .sub_clock_pin(sub_clock_pin),
    .sub_tick     (sub_tick)
  );

  // Prescaler bit chosen by the select code; used only by the operating tick mask logic.
  function automatic logic [2:0] div_index(input logic [3:0] sel);
    if (sel[lcdfc_pkg::BIT_SYSCLK_SELECT]) begin
      div_index = sel[2:0];
    end else if (sel[1]) begin
      div_index = 3'h2;
    end else begin
      div_index = {2'b00, sel[0]};
    end
  endfunction

  assign frame_clock_select = display_control_q[3:0];
  // Halt and module standby both stop the controller; registers are untouched.
  assign running  = display_control_q[lcdfc_pkg::BIT_ACTIVATE] &&
                    clock_gate_two_q[lcdfc_pkg::BIT_MODULE_RUN];
  // In sub modes the system clock enable is absent, so system selections stall.
  assign sub_mode = mode_control_q[lcdfc_pkg::BIT_SUB_MODE];
  assign src_tick = frame_clock_select[lcdfc_pkg::BIT_SYSCLK_SELECT] ?
                    (sysclk_tick && !sub_mode) : sub_tick;

  // Restart the prescaler when the select code changes.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_q <= 4'h0;
    end else begin
      sel_q <= frame_clock_select;
    end
  end
  assign sel_changed = sel_q != frame_clock_select;

  // Binary prescaler: a carry out of bit n is a divide by 2^(n+1) of the source.
  always_ff @(posedge clk) begin
    if (sys_rst || !running || sel_changed) begin
      pre_q <= 8'h00;
    end else if (src_tick) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // For sub selections index 0 means undivided; system selections start at /2.
  always_comb begin
    logic [7:0] mask;
    mask = 8'h00;
    if (frame_clock_select[lcdfc_pkg::BIT_SYSCLK_SELECT]) begin
      mask = 8'((9'h002 << div_index(frame_clock_select)) - 9'h001);
      op_tick = src_tick && ((pre_q & mask) == mask);
    end else if (div_index(frame_clock_select) == 3'h0) begin
      op_tick = src_tick;
    end else begin
      mask = 8'((9'h001 << div_index(frame_clock_select)) - 9'h001);
      op_tick = src_tick && ((pre_q & mask) == mask);
    end
  end

  // Frame length: 256 operating ticks, or three quarters at one third duty.
  assign frame_len = mode_control_q[lcdfc_pkg::BIT_ONE_THIRD] ?
                     lcdfc_pkg::TICKS_ONE_THIRD : lcdfc_pkg::TICKS_PER_FRAME;

  // Frame counter; cleared while halted so operation resumes from a clean frame.
  always_ff @(posedge clk) begin
    if (sys_rst || !running || sel_changed) begin
      frame_cnt_q <= 16'h0000;
    end else if (op_tick) begin
      if (frame_cnt_q >= frame_len - 16'h0001) begin
        frame_cnt_q <= 16'h0000;
      end else begin
        frame_cnt_q <= frame_cnt_q + 16'h0001;
      end
    end
  end

  // Frame strobe and alternation signal are registered.
  always_ff @(posedge clk) begin
    if (sys_rst || !running) begin
      frame_strobe  <= 1'b0;
      alternation_q <= 1'b0;
    end else begin
      frame_strobe <= op_tick && (frame_cnt_q >= frame_len - 16'h0001);
      if (op_tick && (frame_cnt_q >= frame_len - 16'h0001)) begin
        alternation_q <= !alternation_q;
      end
    end
  end

  // Output controls are registered from the control fields.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_enable      <= 1'b0;
      blank_display     <= 1'b1;
      waveform_b_select <= 1'b0;
      drive_supply_on   <= 1'b0;
      divider_connected <= 1'b1;
    end else begin
      drive_enable      <= running;
      blank_display     <= !display_control_q[lcdfc_pkg::BIT_SHOW_DATA];
      waveform_b_select <= waveform_divider_q[lcdfc_pkg::BIT_WAVEFORM_B];
      drive_supply_on   <= display_control_q[lcdfc_pkg::BIT_SUPPLY_SWITCH] && running &&
                           !mode_control_q[lcdfc_pkg::BIT_STANDBY_MODE];
      divider_connected <= waveform_divider_q[3:0] != lcdfc_pkg::DIVIDER_REMOVE_CODE;
    end
  end

  // Status: running, alternation, low bits of the frame counter.
  assign frame_status = {running, alternation_q, 2'b00, frame_cnt_q[3:0]};

  // Supply stays off whenever activate is low.
  supply_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !display_control_q[lcdfc_pkg::BIT_ACTIVATE] |=> !drive_supply_on)
    else $error("supply on while halted");
  blank_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    !display_control_q[lcdfc_pkg::BIT_SHOW_DATA] |=> blank_display)
    else $error("display not blanked");
  wave_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 waveform_b_select == $past(waveform_divider_q[lcdfc_pkg::BIT_WAVEFORM_B]))
    else $error("waveform select mismatch");
  divider_code_a: assert property (@(posedge clk) disable iff (sys_rst)
    waveform_divider_q[3:0] == lcdfc_pkg::DIVIDER_REMOVE_CODE |=> !divider_connected)
    else $error("divider not removed");
  standby_a: assert property (@(posedge clk) disable iff (sys_rst)
    !clock_gate_two_q[lcdfc_pkg::BIT_MODULE_RUN] |=> !drive_enable && !drive_supply_on)
    else $error("driver active in module standby");
  clear_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
    !running |=> frame_cnt_q == 16'h0000 && pre_q == 8'h00)
    else $error("divider not cleared while halted");
  sub_stall_a: assert property (@(posedge clk) disable iff (sys_rst)
    sub_mode && frame_clock_select[lcdfc_pkg::BIT_SYSCLK_SELECT] |-> !op_tick)
    else $error("system source ticks in sub mode");
  supply_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && display_control_q[lcdfc_pkg::BIT_SUPPLY_SWITCH] &&
    !mode_control_q[lcdfc_pkg::BIT_STANDBY_MODE] |=> drive_supply_on)
    else $error("supply not switched on");

  // Helper: source ticks since the last operating tick, cleared wherever the prescaler is.
  // A counter keeps the ratio check cheap; a repetition of up to 256 would not unroll well.
  logic [8:0] tick_gap_q;

  always_ff @(posedge clk) begin
    if (sys_rst || !running || sel_changed) begin
      tick_gap_q <= 9'h000;
    end else if (src_tick) begin
      if (op_tick) begin
        tick_gap_q <= 9'h000;
      end else begin
        tick_gap_q <= tick_gap_q + 9'h001;
      end
    end
  end

  // Divide ratio of the operating clock, decoded apart from the prescaler mask on purpose.
  function automatic logic [8:0] op_ratio(input logic [3:0] sel);
    if (sel[lcdfc_pkg::BIT_SYSCLK_SELECT]) begin
      op_ratio = 9'h002 << sel[2:0];
    end else if (sel[1]) begin
      op_ratio = 9'h004;
    end else if (sel[0]) begin
      op_ratio = 9'h002;
    end else begin
      op_ratio = 9'h001;
    end
  endfunction

  // Each operating tick comes exactly one ratio of source ticks after the last one.
  tick_ratio_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && !sel_changed && op_tick |->
      tick_gap_q + 9'h001 == op_ratio(frame_clock_select))
    else $error("operating clock ratio wrong");

  // A frame ends on the operating tick that meets the last count of the frame.
  sequence frame_end_s;
    running && op_tick && frame_cnt_q >= frame_len - 16'h0001;
  endsequence
  // The next cycle shows the strobe, the flipped alternation and a cleared counter.
  sequence frame_next_s;
    frame_strobe && alternation_q != $past(alternation_q) && frame_cnt_q == 16'h0000;
  endsequence
  frame_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    frame_end_s |=> frame_next_s)
    else $error("frame end not marked");
  // A strobe lasts one cycle, since a frame is far longer than two ticks.
  strobe_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    frame_strobe |=> !frame_strobe)
    else $error("frame strobe longer than one cycle");
  // Inside a frame every operating tick advances the count by one.
  count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && !sel_changed && op_tick && frame_cnt_q < frame_len - 16'h0001 |=>
      frame_cnt_q == $past(frame_cnt_q) + 16'h0001)
    else $error("frame count did not advance");
  // Without an operating tick the frame count holds.
  count_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && !sel_changed && !op_tick |=> $stable(frame_cnt_q))
    else $error("frame count moved without a tick");
  // The count never reaches the full frame length, even when duty changes mid-frame.
  count_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    frame_cnt_q < lcdfc_pkg::TICKS_PER_FRAME)
    else $error("frame count out of range");
  // A new select code restarts prescaler and frame from zero.
  sel_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    sel_changed |=> pre_q == 8'h00 && frame_cnt_q == 16'h0000 && tick_gap_q == 9'h000)
    else $error("select change did not restart divider");
  // The supply follows the switch off one cycle later.
  switch_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !display_control_q[lcdfc_pkg::BIT_SUPPLY_SWITCH] |=> !drive_supply_on)
    else $error("supply on with switch off");
  // Standby power mode forces the supply off whatever the switch says.
  standby_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode_control_q[lcdfc_pkg::BIT_STANDBY_MODE] |=> !drive_supply_on)
    else $error("supply on in standby mode");
  // Halting keeps every register as it was; only a bus write may change one.
  retain_a: assert property (@(posedge clk) disable iff (sys_rst)
    !display_control_q[lcdfc_pkg::BIT_ACTIVATE] && !(psel && penable && pwrite) |=>
      $stable(display_control_q) && $stable(waveform_divider_q) &&
      $stable(clock_gate_two_q) && $stable(mode_control_q))
    else $error("register changed while halted");
  // Display data shows when the data control is set.
  show_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    display_control_q[lcdfc_pkg::BIT_SHOW_DATA] |=> !blank_display)
    else $error("display blanked while shown");
  // Activate with module standby released drives the panel.
  drive_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    running |=> drive_enable)
    else $error("driver idle while running");
  // Every code but the removal code keeps the divider connected.
  divider_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    waveform_divider_q[3:0] != lcdfc_pkg::DIVIDER_REMOVE_CODE |=> divider_connected)
    else $error("divider removed for wrong code");
endmodule
`default_nettype wire

// ==== rtl/lcdfc_pkg.sv ====
package lcdfc_pkg;
  // Register byte addresses on the APB slave.
  localparam logic [11:0] ADDR_DISPLAY_CONTROL  = 12'h000;
  localparam logic [11:0] ADDR_WAVEFORM_DIVIDER = 12'h004;
  localparam logic [11:0] ADDR_CLOCK_GATE_TWO   = 12'h008;
  localparam logic [11:0] ADDR_STATUS           = 12'h00C;
  localparam logic [11:0] ADDR_MODE_CONTROL     = 12'h010;
  // Reset values.
  localparam logic [7:0] RST_DISPLAY_CONTROL  = 8'h80;
  localparam logic [7:0] RST_WAVEFORM_DIVIDER = 8'h60;
  localparam logic [7:0] RST_CLOCK_GATE_TWO   = 8'hFF;
  localparam logic [7:0] RST_MODE_CONTROL     = 8'h00;
  // Bits that always read as one, and the writable bits.
  localparam logic [7:0] FIXED_ONES_DISPLAY  = 8'h80;
  localparam logic [7:0] FIXED_ONES_WAVEFORM = 8'h60;
  localparam logic [7:0] WRITABLE_DISPLAY    = 8'h7F;
  localparam logic [7:0] WRITABLE_WAVEFORM   = 8'h9F;
  // Field positions.
  localparam int BIT_SUPPLY_SWITCH = 6;
  localparam int BIT_ACTIVATE      = 5;
  localparam int BIT_SHOW_DATA     = 4;
  localparam int BIT_SYSCLK_SELECT = 3;
  localparam int BIT_WAVEFORM_B    = 7;
  localparam int BIT_MODULE_RUN    = 0;
  localparam int BIT_SUB_MODE      = 0;
  localparam int BIT_STANDBY_MODE  = 1;
  localparam int BIT_ONE_THIRD     = 2;
  // Split-resistance code that removes the divider.
  localparam logic [3:0] DIVIDER_REMOVE_CODE = 4'h7;
  // Frame timing: sub-clock 32.768 kHz gives 128 Hz, so 256 sub ticks per frame.
  localparam int          SUB_CLOCK_HZ      = 32768;
  localparam int          BASE_FRAME_HZ     = 128;
  localparam logic [15:0] TICKS_PER_FRAME   = 16'(SUB_CLOCK_HZ / BASE_FRAME_HZ);
  // One third duty shortens the frame to three quarters.
  localparam logic [15:0] TICKS_ONE_THIRD   = 16'(SUB_CLOCK_HZ / BASE_FRAME_HZ * 3 / 4);
  localparam logic [7:0]  DIV_TOP           = 8'hFF;
  // APB error-free default read value.
  localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
endpackage

// ==== rtl/lcdfc_apb_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdfc_apb_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [7:0]  frame_status,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  output logic      [7:0]  display_control_q,
  output logic      [7:0]  waveform_divider_q,
  output logic      [7:0]  clock_gate_two_q,
  output logic      [7:0]  mode_control_q
);
  logic wr_en;
  logic mapped;

  // Zero-wait slave; unmapped addresses answer with pslverr.
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign mapped  = (paddr == lcdfc_pkg::ADDR_DISPLAY_CONTROL) ||
                   (paddr == lcdfc_pkg::ADDR_WAVEFORM_DIVIDER) ||
                   (paddr == lcdfc_pkg::ADDR_CLOCK_GATE_TWO) ||
                   (paddr == lcdfc_pkg::ADDR_STATUS) ||
                   (paddr == lcdfc_pkg::ADDR_MODE_CONTROL);
  assign pslverr = psel && penable && !mapped;

  // Writable bits store as written; fixed-one bits ignore writes.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      display_control_q  <= lcdfc_pkg::RST_DISPLAY_CONTROL;
      waveform_divider_q <= lcdfc_pkg::RST_WAVEFORM_DIVIDER;
      clock_gate_two_q   <= lcdfc_pkg::RST_CLOCK_GATE_TWO;
      mode_control_q     <= lcdfc_pkg::RST_MODE_CONTROL;
    end else if (wr_en) begin
      case (paddr)
        lcdfc_pkg::ADDR_DISPLAY_CONTROL: display_control_q <=
          (pwdata[7:0] & lcdfc_pkg::WRITABLE_DISPLAY) | lcdfc_pkg::FIXED_ONES_DISPLAY;
        lcdfc_pkg::ADDR_WAVEFORM_DIVIDER: waveform_divider_q <=
          (pwdata[7:0] & lcdfc_pkg::WRITABLE_WAVEFORM) | lcdfc_pkg::FIXED_ONES_WAVEFORM;
        lcdfc_pkg::ADDR_CLOCK_GATE_TWO: clock_gate_two_q <= pwdata[7:0];
        lcdfc_pkg::ADDR_MODE_CONTROL: mode_control_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data is registered in the setup cycle so it stands in the access phase.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= lcdfc_pkg::READ_ZERO;
    end else if (psel && !penable) begin
      case (paddr)
        lcdfc_pkg::ADDR_DISPLAY_CONTROL:  prdata <= {24'h000000, display_control_q};
        lcdfc_pkg::ADDR_WAVEFORM_DIVIDER: prdata <= {24'h000000, waveform_divider_q};
        lcdfc_pkg::ADDR_CLOCK_GATE_TWO:   prdata <= {24'h000000, clock_gate_two_q};
        lcdfc_pkg::ADDR_STATUS:           prdata <= {24'h000000, frame_status};
        lcdfc_pkg::ADDR_MODE_CONTROL:     prdata <= {24'h000000, mode_control_q};
        default:                          prdata <= lcdfc_pkg::READ_ZERO;
      endcase
    end
  end

  // A write to the fixed-one waveform bits 6:5 never changes them.
  fixed_ones_a: assert property (@(posedge clk) disable iff (sys_rst)
    waveform_divider_q[6:5] == 2'b11)
    else $error("fixed waveform bits lost");
  // A display control write reads back exactly in its writable bits 6:0.
  readback_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en && paddr == lcdfc_pkg::ADDR_DISPLAY_CONTROL |=>
      display_control_q[6:0] == $past(pwdata[6:0]))
    else $error("display control readback mismatch");
endmodule
`default_nettype wire

// ==== rtl/lcdfc_sub_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdfc_sub_tick (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sub_clock_pin,
  output logic      sub_tick
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Two-stage synchroniser; only sync_q feeds the edge detector.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= sub_clock_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // One-cycle enable per rising sub-clock edge.
  assign sub_tick = sync_q && !last_q;
endmodule
`default_nettype wire

// ==== testbench/lcdfc_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Panel side: a shortened watch crystal of 4 cycles and a frame-spacing observer.
module lcdfc_panel_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        frame_strobe,
  output logic             sub_clock_pin,
  output logic      [15:0] frame_count,
  output logic      [31:0] frame_gap
);
  logic [1:0]  phase_q;
  logic [31:0] since_q;

  // The crystal keeps running in the sub-clock power modes, unlike the system clock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign sub_clock_pin = phase_q[1];

  // Spacing is taken from strobe to strobe, so a frame cut short by a select change is seen.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      since_q     <= 32'h0;
      frame_gap   <= 32'h0;
      frame_count <= 16'h0;
    end else if (frame_strobe) begin
      frame_gap   <= since_q + 32'h1;
      since_q     <= 32'h0;
      frame_count <= frame_count + 16'h1;
    end else begin
      since_q <= since_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/lcd_control_frame_clock_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_control_frame_clock_tb_top;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr, sysclk_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, frame_gap;
  logic        drive_enable, blank_display, waveform_b_select, drive_supply_on;
  logic        divider_connected, frame_strobe, alternation_q, sub_clock_pin;
  logic [15:0] frame_count, frame_base;
  int          n_errors, compares;

  lcdfc_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .sub_clock_pin(sub_clock_pin), .sysclk_tick(sysclk_tick),
    .drive_enable(drive_enable), .blank_display(blank_display),
    .waveform_b_select(waveform_b_select), .drive_supply_on(drive_supply_on),
    .divider_connected(divider_connected), .frame_strobe(frame_strobe),
    .alternation_q(alternation_q));
  lcdfc_panel_model panel (.clk(clk), .sys_rst(sys_rst), .frame_strobe(frame_strobe),
    .sub_clock_pin(sub_clock_pin), .frame_count(frame_count), .frame_gap(frame_gap));

  // Clock toggles every half period of 12.5 ns.
  always #12.5 clk = ~clk;

  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", 32'h1, 32'h0);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Outputs follow the registers a cycle late, so two edges pass before they are judged.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    repeat (2) @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk("register read", {24'h0, e}, rdata);
  endtask

  task automatic quiet(input int n);
    logic [15:0] s;
    s = frame_count;
    repeat (n) @(posedge clk);
    chk("frames while stopped", {16'h0, s}, {16'h0, frame_count});
  endtask

  // The second strobe after a select change bounds a frame wholly in the new setting.
  task automatic frames(input logic [7:0] md, input logic [3:0] cs, input logic [31:0] g);
    logic [15:0] s;
    int          n;
    wr(lcdfc_pkg::ADDR_MODE_CONTROL, md);
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, {4'h7, cs});
    s = frame_count;
    n = 0;
    while (16'(frame_count - s) < 16'h2 && n < 3 * g + 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3 * g + 400) chk("frame wait", 32'h1, 32'h0);
    chk("frame spacing", g, frame_gap);
    // Alternation has flipped once per frame counted since the last clean restart.
    chk("alternation", {31'h0, frame_count[0] ^ frame_base[0]}, {31'h0, alternation_q});
  endtask

  task automatic t_reset();
    rd(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h80);
    rd(lcdfc_pkg::ADDR_WAVEFORM_DIVIDER, 8'h60);
    rd(lcdfc_pkg::ADDR_CLOCK_GATE_TWO, 8'hFF);
    chk("levels", 32'h9, {27'h0, drive_enable, blank_display, waveform_b_select,
      drive_supply_on, divider_connected});
  endtask

  task automatic t_fields();
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h00);
    rd(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h80);
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h7F);
    rd(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'hFF);
    wr(lcdfc_pkg::ADDR_WAVEFORM_DIVIDER, 8'h00);
    rd(lcdfc_pkg::ADDR_WAVEFORM_DIVIDER, 8'h60);
    wr(lcdfc_pkg::ADDR_WAVEFORM_DIVIDER, 8'h87);
    rd(lcdfc_pkg::ADDR_WAVEFORM_DIVIDER, 8'hE7);
    chk("b wave and divider", 32'h2, {30'h0, waveform_b_select, divider_connected});
    wr(lcdfc_pkg::ADDR_WAVEFORM_DIVIDER, 8'h0F);
    chk("b wave and divider", 32'h1, {30'h0, waveform_b_select, divider_connected});
    wr(lcdfc_pkg::ADDR_WAVEFORM_DIVIDER, 8'h06);
    chk("divider", 32'h1, {31'h0, divider_connected});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error and data", 32'h1, {31'h0, perr} | rdata);
  endtask

  task automatic t_power();
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h70);
    chk("run show supply", 32'h5, {29'h0, drive_enable, blank_display, drive_supply_on});
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h50);
    chk("halted", 32'h0, {30'h0, drive_enable, drive_supply_on});
    quiet(2500);
    rd(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'hD0);
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h70);
    wr(lcdfc_pkg::ADDR_CLOCK_GATE_TWO, 8'hFE);
    chk("module standby", 32'h0, {30'h0, drive_enable, drive_supply_on});
    quiet(2500);
    rd(lcdfc_pkg::ADDR_STATUS, 8'h00);
    wr(lcdfc_pkg::ADDR_CLOCK_GATE_TWO, 8'hFF);
    chk("standby left", 32'h3, {30'h0, drive_enable, drive_supply_on});
    frame_base = frame_count;
    wr(lcdfc_pkg::ADDR_MODE_CONTROL, 8'h02);
    chk("supply in standby", 32'h0, {31'h0, drive_supply_on});
    wr(lcdfc_pkg::ADDR_MODE_CONTROL, 8'h00);
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h60);
    chk("blank", 32'h1, {31'h0, blank_display});
  endtask

  task automatic t_rates();
    frames(8'h00, 4'h0, 32'h400);
    frames(8'h00, 4'h1, 32'h800);
    frames(8'h00, 4'h2, 32'h1000);
    frames(8'h00, 4'h3, 32'h1000);
    frames(8'h00, 4'h4, 32'h400);
    frames(8'h04, 4'h0, 32'h300);
    for (int i = 0; i < 5; i++) frames(8'h00, 4'(8 + i), 32'h100 << (i + 1));
  endtask

  // In sub mode the system clock stops, so only a sub-clock source keeps frames coming.
  task automatic t_sleep();
    // The tick runs on at first, so the sub-mode gate alone must stop a system source.
    wr(lcdfc_pkg::ADDR_MODE_CONTROL, 8'h01);
    wr(lcdfc_pkg::ADDR_DISPLAY_CONTROL, 8'h78);
    quiet(3000);
    sysclk_tick <= 1'b0;
    frames(8'h01, 4'h0, 32'h400);
    sysclk_tick <= 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sysclk_tick = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_power();
    t_rates();
    t_sleep();
    complete_run();
  end

  // Normal run needs about 70000 cycles.
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end
endmodule
`default_nettype wire
